/* logic/dsag_defines.svh */
// Constants for the dual space address generator
`ifndef DSAG_DEFINES_SVH
`define DSAG_DEFINES_SVH

`define DSAG_ADDR_W      16
`define DSAG_REG_IDX_W   4
`define DSAG_LIT_W       16
`define DSAG_WORD_STEP   16'h0002
`define DSAG_XY_BOUNDARY 16'h0900
`define DSAG_PTR_XA      4'h8
`define DSAG_PTR_XB      4'h9
`define DSAG_PTR_YA      4'ha
`define DSAG_PTR_YB      4'hb
`define DSAG_PTR_IDX     4'hc
`define DSAG_BRANCH_W    16
`define DSAG_IRQ_OFF_W   14
`define DSAG_ADDR_RST    16'h0000

`endif

/* logic/dsag_pkg.sv */
// Types for the dual space address generator
package dsag_pkg;

   typedef enum logic [2:0] {
      DSAG_MODE_IND,
      DSAG_MODE_POST,
      DSAG_MODE_PRE,
      DSAG_MODE_IDX,
      DSAG_MODE_LIT
   } dsag_mode_t;

   typedef enum logic [1:0] {
      DSAG_MAC_IND,
      DSAG_MAC_POST,
      DSAG_MAC_IDX
   } dsag_mac_mode_t;

endpackage

/* logic/dsag_top.sv */
// Dual X/Y data space address generation for the core
//
// What this block does
// - X and Y separate or one unified range
// - X read bus serves unified and X prefetch
// - Y read fetches alongside X for MAC
// - Modulo both spaces, bit-reverse X writes only
// - All writes unified, fixed X/Y boundary
// - Sixteen bit byte addresses, 64 Kbytes
// - Indirect uses register, leaves it unchanged
// - Post-modify: use register, then step
// - Pre-modify: step register, then use
// - Indexed adds base and offset registers
// - Literal offset adds register and literal
// - Move modes share one offset field
// - Prefetch pointers fixed to X or Y unit
// - MAC indexing only on second pointers
// - MAC post-modify only by 2, 4, 6
// - Branch and disable literals, fixed widths
`timescale 1ns/1ps
`default_nettype none
`include "dsag_defines.svh"

module dsag_top #(
   parameter logic [15:0] XY_BOUNDARY = `DSAG_XY_BOUNDARY
) (
   // Clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    nrst,
   // General instruction request
   input  wire logic                    gen_valid,
   input  wire logic                    gen_is_write,
   input  wire dsag_pkg::dsag_mode_t    gen_mode,
   input  wire logic [3:0]              gen_base_sel,
   input  wire logic [3:0]              offset_work_reg,
   input  wire logic [15:0]             gen_step,
   input  wire logic [15:0]             gen_literal,
   input  wire logic                    mod_en,
   input  wire logic [15:0]             mod_start,
   input  wire logic [15:0]             mod_end,
   input  wire logic                    bitrev_en,
   input  wire logic [15:0]             bitrev_mod,
   // Move destination sharing the offset field
   input  wire logic                    mov_valid,
   input  wire dsag_pkg::dsag_mode_t    mov_dst_mode,
   input  wire logic [3:0]              mov_dst_sel,
   input  wire logic [15:0]             mov_dst_step,
   input  wire logic [15:0]             mov_dst_literal,
   // Multiply accumulate prefetch
   input  wire logic                    mac_valid,
   input  wire logic                    mac_x_en,
   input  wire logic                    mac_x_sel_b,
   input  wire dsag_pkg::dsag_mac_mode_t mac_x_mode,
   input  wire logic [1:0]              mac_x_amt,
   input  wire logic                    mac_y_en,
   input  wire logic                    mac_y_sel_b,
   input  wire dsag_pkg::dsag_mac_mode_t mac_y_mode,
   input  wire logic [1:0]              mac_y_amt,
   // Literal fields of other instructions
   input  wire logic [15:0]             branch_instr,
   input  wire logic [13:0]             irq_disable_instr,
   // Working register file view
   input  wire logic [255:0]            work_regs,
   // Working register write back
   output logic                         wb_en_ff,
   output logic [3:0]                   wb_sel_ff,
   output logic [15:0]                  wb_val_ff,
   output logic                         wb2_en_ff,
   output logic [3:0]                   wb2_sel_ff,
   output logic [15:0]                  wb2_val_ff,
   // X read bus, unified view and X prefetch
   output logic                         x_rd_en_ff,
   output logic [15:0]                  x_rd_addr_ff,
   output logic                         x_rd_in_y_ff,
   // X write bus, unified view
   output logic                         x_wr_en_ff,
   output logic [15:0]                  x_wr_addr_ff,
   // Y read bus
   output logic                         y_rd_en_ff,
   output logic [15:0]                  y_rd_addr_ff,
   // Status
   output logic                         mac_err_ff,
   output logic [15:0]                  branch_offset_ff,
   output logic [13:0]                  irq_off_cnt_ff
);
   import dsag_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] reg_val(input logic [255:0] rf, input logic [3:0] sel);
      reg_val = rf[{sel, 4'h0} +: 16];
   endfunction

   // Wrap inside a circular buffer; only the crossing address is corrected
   function automatic logic [15:0] modulo(input logic [15:0] a,
                                          input logic [15:0] s,
                                          input logic [15:0] e,
                                          input logic        en);
      modulo = a;
      if (en) begin
         if (a > e) begin
            modulo = s + (a - e) - `DSAG_WORD_STEP;
         end else if (a < s) begin
            modulo = e - (s - a) + `DSAG_WORD_STEP;
         end
      end
   endfunction

   function automatic logic [15:0] bitrev_add(input logic [15:0] a, input logic [15:0] m);
      logic [15:0] ra;
      logic [15:0] rm;
      logic [15:0] sum;
      for (int i = 0; i < 16; i++) begin
         ra[i] = a[15 - i];
         rm[i] = m[15 - i];
      end
      sum = ra + rm;
      for (int i = 0; i < 16; i++) begin
         bitrev_add[i] = sum[15 - i];
      end
   endfunction

   function automatic logic [15:0] mac_step(input logic [1:0] amt);
      case (amt)
         2'h1:    mac_step = 16'h0002;
         2'h2:    mac_step = 16'h0004;
         2'h3:    mac_step = 16'h0006;
         default: mac_step = 16'h0000;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // General source operand
   logic [15:0] g_base;
   logic [15:0] g_offs;
   logic [15:0] g_ea;
   logic [15:0] g_upd;
   logic        g_upd_en;
   logic [15:0] g_upd_m;
   logic [15:0] g_ea_m;

   assign g_base = reg_val(work_regs, gen_base_sel);
   assign g_offs = (gen_mode == DSAG_MODE_IDX) ? reg_val(work_regs, offset_work_reg)
                                                : gen_literal;

   dsag_unit u_gen (
      .pre_mode  (gen_mode == DSAG_MODE_PRE),
      .post_mode (gen_mode == DSAG_MODE_POST),
      .idx_mode  (gen_mode == DSAG_MODE_IDX),
      .lit_mode  (gen_mode == DSAG_MODE_LIT),
      .base_val  (g_base),
      .offs_val  (g_offs),
      .step      (gen_step),
      .eff_addr  (g_ea),
      .upd_val   (g_upd),
      .upd_en    (g_upd_en)
   );

   // Bit reverse only on X writes, modulo elsewhere
   always_comb begin
      g_upd_m = modulo(g_upd, mod_start, mod_end, mod_en);
      if (bitrev_en && gen_is_write && gen_mode == DSAG_MODE_POST) begin
         g_upd_m = bitrev_add(g_base, bitrev_mod);
      end
   end
   assign g_ea_m = (gen_mode == DSAG_MODE_PRE) ? g_upd_m : g_ea;

   ////////////////////////////////////////////////////////////////////////////
   // Move destination operand, shares offset_work_reg
   logic [15:0] m_base;
   logic [15:0] m_offs;
   logic [15:0] m_ea;
   logic [15:0] m_upd;
   logic        m_upd_en;
   logic [15:0] m_upd_m;
   logic [15:0] m_ea_m;

   assign m_base = reg_val(work_regs, mov_dst_sel);
   assign m_offs = (mov_dst_mode == DSAG_MODE_IDX) ? reg_val(work_regs, offset_work_reg)
                                                   : mov_dst_literal;

   dsag_unit u_mov (
      .pre_mode  (mov_dst_mode == DSAG_MODE_PRE),
      .post_mode (mov_dst_mode == DSAG_MODE_POST),
      .idx_mode  (mov_dst_mode == DSAG_MODE_IDX),
      .lit_mode  (mov_dst_mode == DSAG_MODE_LIT),
      .base_val  (m_base),
      .offs_val  (m_offs),
      .step      (mov_dst_step),
      .eff_addr  (m_ea),
      .upd_val   (m_upd),
      .upd_en    (m_upd_en)
   );
   assign m_upd_m = modulo(m_upd, mod_start, mod_end, mod_en);
   assign m_ea_m  = (mov_dst_mode == DSAG_MODE_PRE) ? m_upd_m : m_ea;

   ////////////////////////////////////////////////////////////////////////////
   // Prefetch pointers are hard wired to their unit
   logic [3:0]  x_sel;
   logic [3:0]  y_sel;
   logic [15:0] x_ptr;
   logic [15:0] y_ptr;
   logic        x_bad;
   logic        y_bad;
   logic [15:0] x_ea;
   logic [15:0] y_ea;
   logic [15:0] x_upd;
   logic [15:0] y_upd;

   assign x_sel = mac_x_sel_b ? `DSAG_PTR_XB : `DSAG_PTR_XA;
   assign y_sel = mac_y_sel_b ? `DSAG_PTR_YB : `DSAG_PTR_YA;
   assign x_ptr = reg_val(work_regs, x_sel);
   assign y_ptr = reg_val(work_regs, y_sel);

   // Indexing only on second pointers; zero step refused
   assign x_bad = (mac_x_mode == DSAG_MAC_IDX && !mac_x_sel_b) ||
                  (mac_x_mode == DSAG_MAC_POST && mac_x_amt == 2'h0);
   assign y_bad = (mac_y_mode == DSAG_MAC_IDX && !mac_y_sel_b) ||
                  (mac_y_mode == DSAG_MAC_POST && mac_y_amt == 2'h0);

   // Index register for the MAC is the fixed companion register
   assign x_ea  = (mac_x_mode == DSAG_MAC_IDX) ? x_ptr + reg_val(work_regs, `DSAG_PTR_IDX) : x_ptr;
   assign y_ea  = (mac_y_mode == DSAG_MAC_IDX) ? y_ptr + reg_val(work_regs, `DSAG_PTR_IDX) : y_ptr;
   assign x_upd = modulo(x_ptr + mac_step(mac_x_amt), mod_start, mod_end, mod_en);
   assign y_upd = modulo(y_ptr + mac_step(mac_y_amt), mod_start, mod_end, mod_en);

   ////////////////////////////////////////////////////////////////////////////
   logic mac_x_go;
   logic mac_y_go;
   assign mac_x_go = mac_valid && mac_x_en && !x_bad;
   assign mac_y_go = mac_valid && mac_y_en && !y_bad;

   // X read bus and Y read bus
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         x_rd_en_ff   <= 1'b0;
         x_rd_addr_ff <= `DSAG_ADDR_RST;
         x_rd_in_y_ff <= 1'b0;
         y_rd_en_ff   <= 1'b0;
         y_rd_addr_ff <= `DSAG_ADDR_RST;
      end else begin
         x_rd_en_ff   <= 1'b0;
         y_rd_en_ff   <= 1'b0;
         if (mac_x_go) begin
            x_rd_en_ff   <= 1'b1;
            x_rd_addr_ff <= x_ea;
            x_rd_in_y_ff <= 1'b0;
         end else if (gen_valid && !gen_is_write) begin
            x_rd_en_ff   <= 1'b1;
            x_rd_addr_ff <= g_ea_m;
            x_rd_in_y_ff <= (g_ea_m >= XY_BOUNDARY);
         end
         if (mac_y_go) begin
            y_rd_en_ff   <= 1'b1;
            y_rd_addr_ff <= y_ea;
         end
      end
   end

   // Writes always use the unified view
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         x_wr_en_ff   <= 1'b0;
         x_wr_addr_ff <= `DSAG_ADDR_RST;
      end else begin
         x_wr_en_ff <= 1'b0;
         if (mov_valid) begin
            x_wr_en_ff   <= 1'b1;
            x_wr_addr_ff <= m_ea_m;
         end else if (gen_valid && gen_is_write) begin
            x_wr_en_ff   <= 1'b1;
            x_wr_addr_ff <= g_ea_m;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pointer write back in the same instruction
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wb_en_ff  <= 1'b0;
         wb_sel_ff <= 4'h0;
         wb_val_ff <= 16'h0000;
      end else begin
         wb_en_ff <= 1'b0;
         if (mac_x_go && mac_x_mode == DSAG_MAC_POST) begin
            wb_en_ff  <= 1'b1;
            wb_sel_ff <= x_sel;
            wb_val_ff <= x_upd;
         end else if (gen_valid && g_upd_en) begin
            wb_en_ff  <= 1'b1;
            wb_sel_ff <= gen_base_sel;
            wb_val_ff <= g_upd_m;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wb2_en_ff  <= 1'b0;
         wb2_sel_ff <= 4'h0;
         wb2_val_ff <= 16'h0000;
      end else begin
         wb2_en_ff <= 1'b0;
         if (mac_y_go && mac_y_mode == DSAG_MAC_POST) begin
            wb2_en_ff  <= 1'b1;
            wb2_sel_ff <= y_sel;
            wb2_val_ff <= y_upd;
         end else if (mov_valid && m_upd_en) begin
            wb2_en_ff  <= 1'b1;
            wb2_sel_ff <= mov_dst_sel;
            wb2_val_ff <= m_upd_m;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Literal capture and MAC mode errors
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mac_err_ff       <= 1'b0;
         branch_offset_ff <= 16'h0000;
         irq_off_cnt_ff   <= 14'h0000;
      end else begin
         mac_err_ff       <= mac_valid && ((mac_x_en && x_bad) || (mac_y_en && y_bad));
         branch_offset_ff <= branch_instr;
         irq_off_cnt_ff   <= irq_disable_instr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_ind_no_wb: assert property (@(posedge clk_sys) disable iff (!nrst)
      (gen_valid && gen_mode == DSAG_MODE_IND && !mac_valid) |=> !wb_en_ff)
      else $error("indirect mode modified pointer");
   a_post_ea: assert property (@(posedge clk_sys) disable iff (!nrst)
      (gen_valid && !gen_is_write && !mac_valid && gen_mode == DSAG_MODE_POST)
      |=> x_rd_addr_ff == $past(g_base))
      else $error("post modify used updated value");
   a_pre_ea: assert property (@(posedge clk_sys) disable iff (!nrst)
      (gen_valid && !mac_valid && gen_mode == DSAG_MODE_PRE && !mod_en)
      |=> wb_en_ff && wb_val_ff == $past(g_base) + $past(gen_step))
      else $error("pre modify write back wrong");
   a_idx_ea: assert property (@(posedge clk_sys) disable iff (!nrst)
      (gen_valid && !gen_is_write && !mac_valid && gen_mode == DSAG_MODE_IDX)
      |=> x_rd_addr_ff == $past(g_base) + $past(reg_val(work_regs, offset_work_reg)))
      else $error("indexed address wrong");
   a_lit_ea: assert property (@(posedge clk_sys) disable iff (!nrst)
      (gen_valid && !gen_is_write && !mac_valid && gen_mode == DSAG_MODE_LIT)
      |=> x_rd_addr_ff == $past(g_base) + $past(gen_literal))
      else $error("literal offset address wrong");
   a_mac_dual: assert property (@(posedge clk_sys) disable iff (!nrst)
      (mac_x_go && mac_y_go) |=> x_rd_en_ff && y_rd_en_ff)
      else $error("MAC fetches not concurrent");
   a_mac_idx_bad: assert property (@(posedge clk_sys) disable iff (!nrst)
      (mac_valid && mac_x_en && mac_x_mode == DSAG_MAC_IDX && !mac_x_sel_b) |=> mac_err_ff)
      else $error("indexing on first X pointer accepted");
   a_mac_step: assert property (@(posedge clk_sys) disable iff (!nrst)
      (mac_x_go && mac_x_mode == DSAG_MAC_POST && !mod_en)
      |=> wb_en_ff && (wb_val_ff - $past(x_ptr)) inside {16'h0002, 16'h0004, 16'h0006})
      else $error("MAC step outside 2, 4, 6");
   a_mac_route: assert property (@(posedge clk_sys) disable iff (!nrst)
      (mac_y_go && mac_y_mode == DSAG_MAC_POST) |=> wb2_sel_ff inside {4'ha, 4'hb})
      else $error("Y pointer not routed to Y unit");
   a_write_uni: assert property (@(posedge clk_sys) disable iff (!nrst)
      (gen_valid && gen_is_write && !mov_valid) |=> x_wr_en_ff && x_wr_addr_ff == $past(g_ea_m))
      else $error("write missed unified bus");

endmodule
`default_nettype wire

/* logic/dsag_unit.sv */
// One address generation unit: effective address and pointer update
`timescale 1ns/1ps
`default_nettype none
`include "dsag_defines.svh"

module dsag_unit (
   // Mode and operands
   input  wire logic               pre_mode,
   input  wire logic               post_mode,
   input  wire logic               idx_mode,
   input  wire logic               lit_mode,
   input  wire logic [15:0]        base_val,
   input  wire logic [15:0]        offs_val,
   input  wire logic [15:0]        step,
   // Results
   output logic      [15:0]        eff_addr,
   output logic      [15:0]        upd_val,
   output logic                    upd_en
);

   always_comb begin
      upd_val  = base_val + step;
      upd_en   = pre_mode | post_mode;
      eff_addr = base_val;
      if (pre_mode) begin
         eff_addr = upd_val;
      end else if (idx_mode | lit_mode) begin
         eff_addr = base_val + offs_val;
      end
   end

endmodule
`default_nettype wire

/* sim/dsag_regfile_model.sv */
// Working register file model standing in for the decoder side
`timescale 1ns/1ps
`default_nettype none

module dsag_regfile_model (
   // Clock and reset
   input  wire logic          clk_sys,
   input  wire logic          nrst,
   // Write back from the block
   input  wire logic          wb_en,
   input  wire logic [3:0]    wb_sel,
   input  wire logic [15:0]   wb_val,
   input  wire logic          wb2_en,
   input  wire logic [3:0]    wb2_sel,
   input  wire logic [15:0]   wb2_val,
   // Software load of a pointer
   input  wire logic          ld_en,
   input  wire logic [3:0]    ld_sel,
   input  wire logic [15:0]   ld_val,
   // Register file view
   output logic      [255:0]  work_regs
);
   logic [15:0] regs_ff [16];

   ////////////////////////////////////////////////////////////////////////////
   // Second port wins a clash, as a later writer would
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int r = 0; r < 16; r++) begin
            regs_ff[r] <= 16'(r * 256 + 64);
         end
      end else begin
         if (ld_en) begin
            regs_ff[ld_sel] <= ld_val;
         end
         if (wb_en) begin
            regs_ff[wb_sel] <= wb_val;
         end
         if (wb2_en) begin
            regs_ff[wb2_sel] <= wb2_val;
         end
      end
   end

   always_comb begin
      for (int r = 0; r < 16; r++) begin
         work_regs[16*r +: 16] = regs_ff[r];
      end
   end
endmodule
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the dual space address generator
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import dsag_pkg::*;
   logic clk_sys = 1'b0, nrst = 1'b0;
   logic gen_valid = 1'b0, gen_is_write = 1'b0, mov_valid = 1'b0, mac_valid = 1'b0;
   dsag_mode_t gen_mode = DSAG_MODE_IND, mov_dst_mode = DSAG_MODE_IND;
   logic [3:0] gen_base_sel = 4'h0, offset_work_reg = 4'h0, mov_dst_sel = 4'h0;
   logic [15:0] gen_step = 16'h0000, gen_literal = 16'h0000;
   logic [15:0] mov_dst_step = 16'h0000, mov_dst_literal = 16'h0000;
   logic mac_x_en = 1'b0, mac_x_sel_b = 1'b0, mac_y_en = 1'b0, mac_y_sel_b = 1'b0;
   dsag_mac_mode_t mac_x_mode = DSAG_MAC_IND, mac_y_mode = DSAG_MAC_IND;
   logic [1:0] mac_x_amt = 2'h0, mac_y_amt = 2'h0;
   logic [15:0] branch_instr = 16'h0000;
   logic [13:0] irq_disable_instr = 14'h0000;
   logic ld_en = 1'b0;
   logic [3:0] ld_sel = 4'h0;
   logic [15:0] ld_val = 16'h0000;
   logic mod_en = 1'b0, bitrev_en = 1'b0;
   logic [15:0] mod_start = 16'h0000, mod_end = 16'hffff, bitrev_mod = 16'h0000;
   logic [255:0] work_regs;
   logic wb_en_ff, wb2_en_ff, x_rd_en_ff, x_rd_in_y_ff, x_wr_en_ff, y_rd_en_ff, mac_err_ff;
   logic [3:0] wb_sel_ff, wb2_sel_ff;
   logic [15:0] wb_val_ff, wb2_val_ff, x_rd_addr_ff, x_wr_addr_ff, y_rd_addr_ff;
   logic [15:0] branch_offset_ff;
   logic [13:0] irq_off_cnt_ff;
   int n_mismatch = 0;
   int total_checks = 0;
   logic [15:0] sh [16];

   always #4 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////////
   // Modulo window and bit reverse driven by the bench
   dsag_top dsag_top_i (.clk_sys(clk_sys), .nrst(nrst), .gen_valid(gen_valid),
      .gen_is_write(gen_is_write), .gen_mode(gen_mode), .gen_base_sel(gen_base_sel),
      .offset_work_reg(offset_work_reg), .gen_step(gen_step), .gen_literal(gen_literal),
      .mod_en(mod_en), .mod_start(mod_start), .mod_end(mod_end), .bitrev_en(bitrev_en),
      .bitrev_mod(bitrev_mod), .mov_valid(mov_valid), .mov_dst_mode(mov_dst_mode),
      .mov_dst_sel(mov_dst_sel), .mov_dst_step(mov_dst_step),
      .mov_dst_literal(mov_dst_literal), .mac_valid(mac_valid), .mac_x_en(mac_x_en),
      .mac_x_sel_b(mac_x_sel_b), .mac_x_mode(mac_x_mode), .mac_x_amt(mac_x_amt),
      .mac_y_en(mac_y_en), .mac_y_sel_b(mac_y_sel_b), .mac_y_mode(mac_y_mode),
      .mac_y_amt(mac_y_amt), .branch_instr(branch_instr),
      .irq_disable_instr(irq_disable_instr), .work_regs(work_regs), .wb_en_ff(wb_en_ff),
      .wb_sel_ff(wb_sel_ff), .wb_val_ff(wb_val_ff), .wb2_en_ff(wb2_en_ff),
      .wb2_sel_ff(wb2_sel_ff), .wb2_val_ff(wb2_val_ff), .x_rd_en_ff(x_rd_en_ff),
      .x_rd_addr_ff(x_rd_addr_ff), .x_rd_in_y_ff(x_rd_in_y_ff), .x_wr_en_ff(x_wr_en_ff),
      .x_wr_addr_ff(x_wr_addr_ff), .y_rd_en_ff(y_rd_en_ff), .y_rd_addr_ff(y_rd_addr_ff),
      .mac_err_ff(mac_err_ff), .branch_offset_ff(branch_offset_ff),
      .irq_off_cnt_ff(irq_off_cnt_ff));

   dsag_regfile_model dsag_regfile_model_i (.clk_sys(clk_sys), .nrst(nrst),
      .wb_en(wb_en_ff), .wb_sel(wb_sel_ff), .wb_val(wb_val_ff), .wb2_en(wb2_en_ff),
      .wb2_sel(wb2_sel_ff), .wb2_val(wb2_val_ff), .ld_en(ld_en), .ld_sel(ld_sel),
      .ld_val(ld_val), .work_regs(work_regs));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("mismatches %0d checks %0d", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   function automatic logic [15:0] ea_of(dsag_mode_t m, logic [3:0] b, logic [3:0] o,
                                         logic [15:0] st, logic [15:0] lt);
      case (m)
         DSAG_MODE_PRE: return sh[b] + st;
         DSAG_MODE_IDX: return sh[b] + sh[o];
         DSAG_MODE_LIT: return sh[b] + lt;
         default:       return sh[b];
      endcase
   endfunction

   function automatic logic mac_bad(logic sb, dsag_mac_mode_t m, logic [1:0] a);
      return (m == DSAG_MAC_IDX && !sb) || (m == DSAG_MAC_POST && a == 2'h0);
   endfunction

   // Circular window of mod_end - mod_start + 2 bytes
   function automatic logic [15:0] wrap(logic [15:0] a);
      logic [15:0] len;
      len = mod_end - mod_start + 16'h0002;
      if (mod_en && a > mod_end) begin
         return a - len;
      end
      if (mod_en && a < mod_start) begin
         return a + len;
      end
      return a;
   endfunction

   function automatic logic [15:0] flip(logic [15:0] v);
      for (int i = 0; i < 16; i++) begin
         flip[i] = v[15 - i];
      end
   endfunction

   // General or move operand; the idle cycle lets write back land first
   task automatic gen_op(logic mv, logic wr, dsag_mode_t m, logic [3:0] b, logic [3:0] o,
                         logic [15:0] st, logic [15:0] lt);
      logic [15:0] ea, up, br;
      logic upd;
      logic [13:0] di;
      ea = ea_of(m, b, o, st, lt);
      up = wrap(sh[b] + st);
      if (!mv && wr && bitrev_en && m == DSAG_MODE_POST) begin
         up = flip(flip(sh[b]) + flip(bitrev_mod));
      end
      if (m == DSAG_MODE_PRE) begin
         ea = up;
      end
      upd = (m == DSAG_MODE_POST || m == DSAG_MODE_PRE);
      br = 16'($urandom);
      di = 14'($urandom);
      @(negedge clk_sys);
      {gen_valid, mov_valid, gen_is_write} = {!mv, mv, wr};
      gen_mode = m;
      mov_dst_mode = m;
      {gen_base_sel, mov_dst_sel, offset_work_reg} = {b, b, o};
      {gen_step, mov_dst_step, gen_literal, mov_dst_literal} = {st, st, lt, lt};
      {branch_instr, irq_disable_instr} = {br, di};
      @(negedge clk_sys);
      {gen_valid, mov_valid} = 2'b00;
      chk("branch", branch_offset_ff, br);
      chk("irq_off", 16'(irq_off_cnt_ff), 16'(di));
      if (mv || wr) begin
         chk("wr_en", 16'(x_wr_en_ff), 16'h0001);
         chk("wr_addr", x_wr_addr_ff, ea);
         chk("rd_en", 16'(x_rd_en_ff), 16'h0000);
      end else begin
         chk("rd_en", 16'(x_rd_en_ff), 16'h0001);
         chk("rd_addr", x_rd_addr_ff, ea);
         chk("rd_in_y", 16'(x_rd_in_y_ff), 16'(ea >= 16'h0900));
      end
      chk("wb_en", 16'(mv ? wb2_en_ff : wb_en_ff), 16'(upd));
      if (upd) begin
         chk("wb_sel", 16'(mv ? wb2_sel_ff : wb_sel_ff), 16'(b));
         chk("wb_val", mv ? wb2_val_ff : wb_val_ff, up);
         sh[b] = up;
      end
   endtask

   task automatic mac_op(logic sb, dsag_mac_mode_t m, logic [1:0] a);
      logic bad;
      logic [15:0] xa, ya, d;
      bad = mac_bad(sb, m, a);
      d = {13'h0000, a, 1'b0};
      xa = sh[8 + sb] + ((m == DSAG_MAC_IDX) ? sh[12] : 16'h0000);
      ya = sh[10 + sb] + ((m == DSAG_MAC_IDX) ? sh[12] : 16'h0000);
      @(negedge clk_sys);
      {mac_valid, mac_x_en, mac_y_en, mac_x_sel_b, mac_y_sel_b} = {3'h7, sb, sb};
      mac_x_mode = m;
      mac_y_mode = m;
      {mac_x_amt, mac_y_amt} = {a, a};
      @(negedge clk_sys);
      mac_valid = 1'b0;
      chk("mac_err", 16'(mac_err_ff), 16'(bad));
      chk("x_fetch", 16'(x_rd_en_ff), 16'(!bad));
      chk("y_fetch", 16'(y_rd_en_ff), 16'(!bad));
      chk("wb_x", 16'(wb_en_ff), 16'(!bad && m == DSAG_MAC_POST));
      chk("wb_y", 16'(wb2_en_ff), 16'(!bad && m == DSAG_MAC_POST));
      if (!bad) begin
         chk("x_addr", x_rd_addr_ff, xa);
         chk("x_in_y", 16'(x_rd_in_y_ff), 16'h0000);
         chk("y_addr", y_rd_addr_ff, ya);
         if (m == DSAG_MAC_POST) begin
            chk("wb_x_val", wb_val_ff, sh[8 + sb] + d);
            chk("wb_y_sel", 16'(wb2_sel_ff), 16'(10 + sb));
            chk("wb_x_sel", 16'(wb_sel_ff), 16'(8 + sb));
            chk("wb_y_val", wb2_val_ff, sh[10 + sb] + d);
            sh[8 + sb] = sh[8 + sb] + d;
            sh[10 + sb] = sh[10 + sb] + d;
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      n_mismatch++;
      final_report();
   end

   initial begin
      logic [15:0] pv [5];
      pv = '{16'h0200, 16'h0300, 16'h0a00, 16'h0b00, 16'h0010};
      void'($urandom(32'h57fc8cef));
      for (int r = 0; r < 16; r++) begin
         sh[r] = 16'(r * 256 + 64);
      end
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("rst_wb", 16'({wb_en_ff, x_rd_en_ff, x_wr_en_ff, y_rd_en_ff}), 16'h0000);
      nrst = 1'b1;
      for (int i = 0; i < 5; i++) begin
         gen_op(i[0], 1'b1, dsag_mode_t'(i), 4'(i), 4'(i + 1), 16'hfffe, 16'h0802);
      end
      for (int i = 0; i < 80; i++) begin
         gen_op(i[4], 1'($urandom), dsag_mode_t'($urandom_range(0, 4)),
                4'($urandom_range(0, 7)), 4'($urandom), 16'($urandom_range(0, 31)) * 2 - 32,
                16'($urandom));
      end
      // Window crossings both ways, then one bit reversed write
      @(negedge clk_sys);
      {ld_en, ld_sel, ld_val} = {1'b1, 4'h1, 16'h011e};
      sh[1] = 16'h011e;
      {mod_en, mod_start, mod_end} = {1'b1, 16'h0100, 16'h011e};
      @(negedge clk_sys);
      ld_en = 1'b0;
      gen_op(1'b0, 1'b0, DSAG_MODE_POST, 4'h1, 4'h0, 16'h0002, 16'h0000);
      gen_op(1'b0, 1'b0, DSAG_MODE_PRE, 4'h1, 4'h0, 16'hfffc, 16'h0000);
      gen_op(1'b1, 1'b1, DSAG_MODE_PRE, 4'h1, 4'h0, 16'h0004, 16'h0000);
      {mod_en, bitrev_en, bitrev_mod} = {1'b0, 1'b1, 16'h0008};
      gen_op(1'b0, 1'b1, DSAG_MODE_POST, 4'h2, 4'h0, 16'h0002, 16'h0000);
      bitrev_en = 1'b0;
      // X pointers below the boundary, Y pointers above it
      for (int i = 0; i < 5; i++) begin
         @(negedge clk_sys);
         {ld_en, ld_sel, ld_val} = {1'b1, 4'(8 + i), pv[i]};
         sh[8 + i] = pv[i];
      end
      @(negedge clk_sys);
      ld_en = 1'b0;
      for (int i = 0; i < 32; i++) begin
         if (i[2:1] != 2'h3) begin
            mac_op(i[0], dsag_mac_mode_t'(i[2:1]), i[4:3]);
         end
      end
      final_report();
   end
endmodule
`default_nettype wire
